// *** include/dbfs_pkg.sv ***
// shared constants, types and bundles of the dual buck fault supervisor
package dbfs_pkg;
	localparam int NCH = 2;
	localparam int CNT_W = 16;
	// consecutive-cycle trip counts
	localparam int OC_TRIP = 32;
	localparam int UV_TRIP = 8;
	localparam int OV_TRIP = 32;
	// switching period and minimum upper-gate on-time, in clock cycles
	localparam int PWM_PERIOD_DEF = 64;
	localparam int MIN_ON_DEF = 4;
	// qualification delay: t = 0.5236 / f(MHz) seconds = 523600 cycles
	localparam int QUAL_COEF_X1E4 = 5236;
	localparam int QUAL_SCALE = 100;
	localparam int QUAL_CYCLES_DEF = QUAL_COEF_X1E4 * QUAL_SCALE;
	// register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [1:0] REG_SEL_NONE = 2'h0;
	localparam logic [1:0] REG_SEL_CTRL = 2'h1;
	localparam logic [1:0] REG_SEL_STATUS = 2'h2;
	// field positions
	localparam int CTRL_SW_OFF_LSB = 0;
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_STATE_W = 3;
	localparam int STAT_POWER_GOOD_FLAG_BIT = 8;
	localparam int STAT_LIN_BIT = 9;
	localparam int STAT_HOLD_BIT = 10;
	localparam int HTRANS_ACTIVE_BIT = 1;
	localparam logic [NCH-1:0] CTRL_RESET = '0;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

	typedef enum logic [2:0] {
		CH_OFF,
		CH_DISCHARGE,
		CH_SOFTSTART,
		CH_RUN,
		CH_LATCHED
	} dbfs_ch_state_t;

	// comparator results of one switching channel
	typedef struct packed {
		logic win_lo_ok;   // feedback above the 90% window edge
		logic win_hi_ok;   // feedback below the 110% window edge
		logic uv;          // feedback at or below 82%
		logic ov;          // feedback at or above 116%
		logic oc;          // switch node below overcurrent_threshold_pin
		logic en_low;      // soft-start/enable pin below 1.0V
		logic ss_near_3v;  // soft-start ramp near 3V
		logic ss_done;     // soft-start ramp at 3.2V
		logic pwm_off;     // modulator asks the upper gate to end
	} dbfs_cmp_t;

	// gate and soft-start drive of one switching channel
	typedef struct packed {
		logic upper;
		logic lower;
		logic oe;
		logic diode_emul;
		logic ss_discharge;
		logic softstart_done;
	} dbfs_gate_t;

	// per-channel state
	typedef struct packed {
		dbfs_ch_state_t state;
		logic oc_seen;
		logic ss_oc;
		logic up_on;
		logic [CNT_W-1:0] on_cnt;
	} dbfs_ch_t;
endpackage

// *** rtl/dbfs_qual_timer.sv ***
// power-good qualification timer
`timescale 1ns/10ps
module dbfs_qual_timer import dbfs_pkg::*; #(
	parameter int CYCLES = QUAL_CYCLES_DEF
) (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic clk_en_in,
	input wire logic cond_in,
	output logic done_out
);
	localparam int TW = $clog2(CYCLES + 1);

	typedef struct packed {
		logic [TW-1:0] cnt;
		logic done;
	} dbfs_qt_t;

	dbfs_qt_t r;
	dbfs_qt_t next_r;

	initial begin
		if (CYCLES < 1)
			$error("qualification cycles must be positive");
	end

	// any lapse restarts a full delay from zero
	always_comb begin
		next_r = r;
		if (!cond_in) begin
			next_r.cnt = '0;
			next_r.done = 1'b0;
		end else if (r.cnt != TW'(CYCLES)) begin
			next_r.cnt = r.cnt + 1'b1;
		end
		next_r.done = cond_in && (next_r.cnt == TW'(CYCLES));
	end

	// register state; power-on reset clears it
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in)
			r <= '0;
		else if (clk_en_in)
			r <= next_r;
	end

	assign done_out = r.done;
endmodule

// *** rtl/dbfs_run_counter.sv ***
// counter of unbroken runs of a fault over switching cycles
`timescale 1ns/10ps
module dbfs_run_counter import dbfs_pkg::*; #(
	parameter int TRIP = 8
) (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic clk_en_in,
	input wire logic step_in,
	input wire logic fault_in,
	input wire logic hold_in,
	output logic trip_out
);
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic trip;
	} dbfs_run_t;

	dbfs_run_t r;
	dbfs_run_t next_r;

	initial begin
		if (TRIP < 1 || TRIP >= (1 << CNT_W))
			$error("run counter trip out of range");
	end

	// count a step with fault, clear on any clean step or while held
	always_comb begin
		next_r = r;
		if (hold_in) begin
			next_r.cnt = '0;
		end else if (step_in) begin
			if (!fault_in)
				next_r.cnt = '0;
			else if (r.cnt != CNT_W'(TRIP))
				next_r.cnt = r.cnt + 1'b1;
		end
		next_r.trip = (next_r.cnt == CNT_W'(TRIP));
	end

	// register state; power-on reset clears it
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in)
			r <= '0;
		else if (clk_en_in)
			r <= next_r;
	end

	assign trip_out = r.trip;
endmodule

// *** rtl/dbfs_top.sv ***
// dual buck fault supervisor: channel sequencing, faults, power good, bus
//
// Overview of operation
// - switcher in range between 90% and 110%
// - linear in range above 75%, no ceiling
// - ramps done and all in range start timer
// - delay follows oscillator only, no adjustment
// - timer expiry releases power-good pull-down
// - any lapse pulls low, then full delay
// - low-side gate off during soft-start
// - second channel starts at half period
// - minimum upper-gate on-time unless overcurrent ends the pulse
// - linear on after power-on, no ramp
// - overcurrent ends upper pulse, counts cycle
// - 32 overcurrent cycles outside soft-start: hiccup
// - hiccup discharges soft-start, then restarts ramp
// - soft-start limits pulses, holds hiccup counter
// - persisting fault repeats hiccup near 3V
// - 8 cycles at 82% causes hiccup
// - at 116% low-side on, diode emulation
// - 32 overvoltage cycles after ramp latch off
// - latch clears by enable, power, undervoltage
// - soft-start done at 3.2V, both gate delay
// - enable low disables; both low hold both
`timescale 1ns/10ps
module dbfs_top import dbfs_pkg::*; #(
	parameter int PWM_PERIOD = PWM_PERIOD_DEF,
	parameter int MIN_ON = MIN_ON_DEF,
	parameter int QUAL_CYCLES = QUAL_CYCLES_DEF
) (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic clk_en_in,
	// comparator results per switching channel
	input wire dbfs_cmp_t [NCH-1:0] ch_cmp_in,
	input wire logic lin_above_75_in,
	// gate drive per switching channel
	output dbfs_gate_t [NCH-1:0] gate_out,
	output logic linear_drive_output_enable_out,
	// open-drain power-good line
	output logic power_good_flag_out,
	output logic power_good_flag_oe_out,
	// register bus
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out
);
	localparam int PW = $clog2(PWM_PERIOD);
	localparam logic [PW-1:0] LAST_TICK = PW'(PWM_PERIOD - 1);
	localparam logic [PW-1:0] HALF_TICK = PW'(PWM_PERIOD / 2);
	localparam logic [CNT_W-1:0] MIN_ON_CNT = CNT_W'(MIN_ON);

	// whole state of the block
	typedef struct packed {
		dbfs_ch_t [NCH-1:0] ch;
		logic [PW-1:0] tick;
		logic both_hold;
		logic lin_en;
		logic pg_released;
		logic ap_valid;
		logic ap_write;
		logic [7:0] ap_addr;
		logic [NCH-1:0] ctrl_sw_off;
		logic [31:0] rdata;
	} dbfs_state_t;

	dbfs_state_t r;
	dbfs_state_t next_r;

	logic [NCH-1:0] cyc_start;
	logic [NCH-1:0] oc_trip;
	logic [NCH-1:0] uv_trip;
	logic [NCH-1:0] ov_trip;
	logic [NCH-1:0] oc_hold;
	logic [NCH-1:0] uv_hold;
	logic [NCH-1:0] ov_hold;
	logic qual_cond;
	logic qual_done;
	logic ap_take;

	initial begin
		if (PWM_PERIOD < 4 || (PWM_PERIOD % 2) != 0)
			$error("switching period must be even and at least 4");
		if (MIN_ON < 1 || MIN_ON >= PWM_PERIOD / 2)
			$error("minimum on-time must fit in half a period");
	end

	// map a byte address onto one of the registers
	function automatic logic [1:0] reg_decode(input logic [7:0] addr);
		if (addr == REG_CTRL)
			return REG_SEL_CTRL;
		else if (addr == REG_STATUS)
			return REG_SEL_STATUS;
		else
			return REG_SEL_NONE;
	endfunction

	// switching channel output inside its power-good window
	function automatic logic sw_in_range(input dbfs_cmp_t c);
		return c.win_lo_ok && c.win_hi_ok;
	endfunction

	// status word built from live state
	function automatic logic [31:0] status_word(input dbfs_state_t s);
		logic [31:0] w;
		w = WORD_ZERO;
		for (int i = 0; i < NCH; i++) begin
			w[STAT_STATE_LSB + i*STAT_STATE_W +: STAT_STATE_W] =
				s.ch[i].state;
		end
		w[STAT_POWER_GOOD_FLAG_BIT] = s.pg_released;
		w[STAT_LIN_BIT] = s.lin_en;
		w[STAT_HOLD_BIT] = s.both_hold;
		return w;
	endfunction

	// cycle starts: channel 1 runs half a period behind channel 0
	assign cyc_start[0] = (r.tick == '0);
	assign cyc_start[1] = (r.tick == HALF_TICK);

	// fault run counters per channel
	generate
		for (genvar g = 0; g < NCH; g++) begin : g_ch
			// overcurrent counter only counts outside soft-start
			assign oc_hold[g] = (r.ch[g].state != CH_RUN);
			// undervoltage watches running and latched channels
			assign uv_hold[g] = (r.ch[g].state != CH_RUN) &&
				(r.ch[g].state != CH_LATCHED);
			// overvoltage counts only once the ramp is done
			assign ov_hold[g] = (r.ch[g].state != CH_RUN);

			dbfs_run_counter #(.TRIP(OC_TRIP)) u_oc (
				.sys_clk_in(sys_clk_in),
				.rst_n_in(rst_n_in),
				.clk_en_in(clk_en_in),
				.step_in(cyc_start[g]),
				.fault_in(r.ch[g].oc_seen),
				.hold_in(oc_hold[g]),
				.trip_out(oc_trip[g])
			);

			dbfs_run_counter #(.TRIP(UV_TRIP)) u_uv (
				.sys_clk_in(sys_clk_in),
				.rst_n_in(rst_n_in),
				.clk_en_in(clk_en_in),
				.step_in(cyc_start[g]),
				.fault_in(ch_cmp_in[g].uv),
				.hold_in(uv_hold[g]),
				.trip_out(uv_trip[g])
			);

			dbfs_run_counter #(.TRIP(OV_TRIP)) u_ov (
				.sys_clk_in(sys_clk_in),
				.rst_n_in(rst_n_in),
				.clk_en_in(clk_en_in),
				.step_in(cyc_start[g]),
				.fault_in(ch_cmp_in[g].ov),
				.hold_in(ov_hold[g]),
				.trip_out(ov_trip[g])
			);
		end
	endgenerate

	// power-good conditions: both ramps done and all outputs in range
	always_comb begin
		qual_cond = lin_above_75_in;
		for (int i = 0; i < NCH; i++) begin
			qual_cond = qual_cond && (r.ch[i].state == CH_RUN) &&
				ch_cmp_in[i].ss_done && sw_in_range(ch_cmp_in[i]);
		end
	end

	dbfs_qual_timer #(.CYCLES(QUAL_CYCLES)) u_qual (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.clk_en_in(clk_en_in),
		.cond_in(qual_cond),
		.done_out(qual_done)
	);

	assign ap_take = hsel_in && hready_in && htrans_in[HTRANS_ACTIVE_BIT];

	// next state of the whole block
	always_comb begin
		next_r = r;

		// free-running switching phase counter
		next_r.tick = (r.tick == LAST_TICK) ? '0 : r.tick + 1'b1;

		// linear output comes on once power-on reset has released
		next_r.lin_en = 1'b1;

		// both enables low: neither may ramp until both are released
		if (ch_cmp_in[0].en_low && ch_cmp_in[1].en_low)
			next_r.both_hold = 1'b1;
		else if (!ch_cmp_in[0].en_low && !ch_cmp_in[1].en_low)
			next_r.both_hold = 1'b0;

		// power good follows the timer; a lapse pulls it low at once
		next_r.pg_released = qual_done && qual_cond;

		for (int i = 0; i < NCH; i++) begin
			// per-cycle overcurrent flag, a new event beats the clear
			if (cyc_start[i])
				next_r.ch[i].oc_seen = 1'b0;
			if (r.ch[i].up_on && ch_cmp_in[i].oc)
				next_r.ch[i].oc_seen = 1'b1;

			// upper gate pulse
			if (r.ch[i].up_on) begin
				next_r.ch[i].on_cnt = r.ch[i].on_cnt + 1'b1;
				if (ch_cmp_in[i].oc)
					next_r.ch[i].up_on = 1'b0;
				else if (ch_cmp_in[i].pwm_off &&
					r.ch[i].on_cnt + 1'b1 >= MIN_ON_CNT)
					next_r.ch[i].up_on = 1'b0;
			end
			if (cyc_start[i]) begin
				next_r.ch[i].on_cnt = '0;
				next_r.ch[i].up_on = (r.ch[i].state == CH_RUN) ||
					(r.ch[i].state == CH_SOFTSTART);
			end

			// channel sequencing
			unique case (r.ch[i].state)
				CH_OFF: begin
					if (!ch_cmp_in[i].en_low && !r.both_hold &&
						!r.ctrl_sw_off[i]) begin
						next_r.ch[i].state = CH_SOFTSTART;
						next_r.ch[i].ss_oc = 1'b0;
					end
				end
				CH_DISCHARGE: begin
					// pin pulled below the enable trip: release it
					if (ch_cmp_in[i].en_low) begin
						next_r.ch[i].state = CH_SOFTSTART;
						next_r.ch[i].ss_oc = 1'b0;
					end
				end
				CH_SOFTSTART: begin
					if (ch_cmp_in[i].oc && r.ch[i].up_on)
						next_r.ch[i].ss_oc = 1'b1;
					if (ch_cmp_in[i].ss_near_3v && r.ch[i].ss_oc)
						next_r.ch[i].state = CH_DISCHARGE;
					else if (ch_cmp_in[i].ss_done)
						next_r.ch[i].state = CH_RUN;
				end
				CH_RUN: begin
					if (oc_trip[i] || uv_trip[i])
						next_r.ch[i].state = CH_DISCHARGE;
					else if (ov_trip[i])
						next_r.ch[i].state = CH_LATCHED;
				end
				CH_LATCHED: begin
					next_r.ch[i].up_on = 1'b0;
					if (uv_trip[i])
						next_r.ch[i].state = CH_DISCHARGE;
				end
				default: begin
					next_r.ch[i].state = CH_OFF;
				end
			endcase

			// external or software disable wins everywhere but discharge
			if ((ch_cmp_in[i].en_low || r.ctrl_sw_off[i]) &&
				r.ch[i].state != CH_DISCHARGE) begin
				next_r.ch[i].state = CH_OFF;
				next_r.ch[i].up_on = 1'b0;
			end

			// no pulse may run on into hiccup or latch-off
			if (next_r.ch[i].state != CH_RUN &&
				next_r.ch[i].state != CH_SOFTSTART)
				next_r.ch[i].up_on = 1'b0;
		end

		// bus slave: address phase capture, data phase write
		next_r.ap_valid = ap_take;
		if (ap_take) begin
			next_r.ap_write = hwrite_in;
			next_r.ap_addr = haddr_in[7:0];
			unique case (reg_decode(haddr_in[7:0]))
				REG_SEL_CTRL: next_r.rdata =
					{{(32-NCH){1'b0}}, r.ctrl_sw_off};
				REG_SEL_STATUS: next_r.rdata = status_word(r);
				default: next_r.rdata = WORD_ZERO;
			endcase
		end
		if (r.ap_valid && r.ap_write &&
			reg_decode(r.ap_addr) == REG_SEL_CTRL)
			next_r.ctrl_sw_off = hwdata_in[CTRL_SW_OFF_LSB +: NCH];
	end

	// register the state; power-on reset sets the defined start
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			r <= '0;
			r.both_hold <= 1'b1;
			r.ctrl_sw_off <= CTRL_RESET;
		end else if (clk_en_in) begin
			r <= next_r;
		end
	end

	// gate drive per channel
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			gate_out[i].upper = r.ch[i].up_on && !ch_cmp_in[i].oc;
			gate_out[i].lower = 1'b0;
			gate_out[i].diode_emul = 1'b0;
			gate_out[i].oe = (r.ch[i].state != CH_LATCHED);
			// discharge only in hiccup; latch-off leaves the cap charged
			gate_out[i].ss_discharge = (r.ch[i].state == CH_DISCHARGE);
			gate_out[i].softstart_done = (r.ch[i].state == CH_RUN) ||
				(r.ch[i].state == CH_LATCHED);
			if (r.ch[i].state == CH_RUN) begin
				if (ch_cmp_in[i].ov) begin
					gate_out[i].upper = 1'b0;
					gate_out[i].lower = 1'b1;
					gate_out[i].diode_emul = 1'b1;
				end else begin
					gate_out[i].lower = !r.ch[i].up_on;
				end
			end
			// soft-start keeps the low side off for a monotonic rise
			if (r.ch[i].state == CH_SOFTSTART)
				gate_out[i].lower = 1'b0;
		end
	end

	assign linear_drive_output_enable_out = r.lin_en;
	// open drain: the pull-down drives low until released
	assign power_good_flag_out = 1'b0;
	assign power_good_flag_oe_out = !r.pg_released;
	assign hrdata_out = r.rdata;
	assign hreadyout_out = 1'b1;
	assign hresp_out = 1'b0;
endmodule

// *** verif/dbfs_stage_model.sv ***
// power stage, soft-start capacitors and power-good pull-up
`timescale 1ns/10ps
module dbfs_stage_model import dbfs_pkg::*; (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire dbfs_gate_t [NCH-1:0] gate_in,
	input wire logic [NCH-1:0] hold_in,
	input wire logic [NCH-1:0] low_in,
	input wire logic [NCH-1:0] high_in,
	input wire logic [NCH-1:0] uv_in,
	input wire logic [NCH-1:0] ov_in,
	input wire logic [NCH-1:0] oc_in,
	input wire logic pg_oe_in,
	input wire logic pg_data_in,
	output dbfs_cmp_t [NCH-1:0] cmp_out,
	output logic pg_line_out
);
	// pull-up lifts the line once the device stops pulling
	assign pg_line_out = pg_oe_in ? pg_data_in : 1'b1;
	for (genvar c = 0; c < NCH; c++) begin : g_ch
		logic [7:0] ramp;
		// capacitor emptied by power-on, external hold or discharge
		always_ff @(posedge sys_clk_in) begin
			if (!rst_n_in || hold_in[c] || gate_in[c].ss_discharge) begin
				ramp <= 8'h00;
			end else if (ramp != 8'hdc) begin
				ramp <= ramp + 8'h01;
			end
		end
		// comparator levels; the modulator always asks for short pulses
		always_comb begin
			cmp_out[c].win_lo_ok = !low_in[c] && !uv_in[c];
			cmp_out[c].win_hi_ok = !high_in[c] && !ov_in[c];
			cmp_out[c].uv = uv_in[c];
			cmp_out[c].ov = ov_in[c];
			cmp_out[c].oc = oc_in[c];
			cmp_out[c].en_low = ramp < 8'h08;
			cmp_out[c].ss_near_3v = ramp >= 8'hc8;
			cmp_out[c].ss_done = ramp >= 8'hdc;
			cmp_out[c].pwm_off = 1'b1;
		end
	end
endmodule

// *** verif/dbfs_sva.sv ***
// port assertions of the dual buck fault supervisor
`timescale 1ns/10ps
module dbfs_sva import dbfs_pkg::*; #(
	parameter int PWM_PERIOD = PWM_PERIOD_DEF,
	parameter int MIN_ON = MIN_ON_DEF,
	parameter int QUAL_CYCLES = QUAL_CYCLES_DEF
) (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire dbfs_cmp_t [NCH-1:0] ch_cmp_in,
	input wire logic lin_above_75_in,
	input wire dbfs_gate_t [NCH-1:0] gate_out,
	input wire logic linear_drive_output_enable_out,
	input wire logic power_good_flag_oe_out
);
	logic all_ok;
	logic up0_q;
	logic [31:0] ok_run;
	logic [7:0] ph_cnt;
	default clocking @(posedge sys_clk_in);
	endclocking
	default disable iff (!rst_n_in);
	// every power-good condition met; a latched channel is not running
	assign all_ok = &{lin_above_75_in, ch_cmp_in[0].win_lo_ok,
		ch_cmp_in[0].win_hi_ok, ch_cmp_in[1].win_lo_ok,
		ch_cmp_in[1].win_hi_ok, gate_out[0].softstart_done,
		gate_out[1].softstart_done, gate_out[0].oe, gate_out[1].oe};
	// clean-run length and cycles since channel 0 began a pulse
	always_ff @(posedge sys_clk_in) begin
		up0_q <= gate_out[0].upper;
		if (!rst_n_in || !all_ok) begin
			ok_run <= 32'h0000_0000;
		end else begin
			ok_run <= ok_run + 32'h0000_0001;
		end
		if (!rst_n_in) begin
			ph_cnt <= 8'hff;
		end else if (gate_out[0].upper && !up0_q) begin
			ph_cnt <= 8'h01;
		end else if (ph_cnt != 8'hff) begin
			ph_cnt <= ph_cnt + 8'h01;
		end
	end
	a_oc_cuts_pulse: assert property (
		ch_cmp_in[0].oc |-> !gate_out[0].upper)
		else $error("upper gate on during overcurrent");
	a_min_on_time: assert property (
		$fell(gate_out[0].upper) && gate_out[0].oe && !ch_cmp_in[0].oc
		&& !ch_cmp_in[0].ov && !ch_cmp_in[0].en_low
		&& !gate_out[0].ss_discharge |-> $past(gate_out[0].upper, MIN_ON))
		else $error("upper pulse shorter than minimum");
	a_ss_low_off: assert property (
		gate_out[0].oe && !gate_out[0].softstart_done |-> !gate_out[0].lower)
		else $error("low-side gate on before ramp done");
	a_ov_low_on: assert property (
		gate_out[0].softstart_done && gate_out[0].oe && ch_cmp_in[0].ov
		|-> gate_out[0].lower && gate_out[0].diode_emul && !gate_out[0].upper)
		else $error("overvoltage did not turn low side on");
	a_latch_keeps_cap: assert property (
		!gate_out[0].oe |-> !gate_out[0].ss_discharge && !gate_out[0].upper)
		else $error("latched channel discharges or switches");
	a_pg_drop: assert property (
		!power_good_flag_oe_out && !all_ok |=> power_good_flag_oe_out)
		else $error("power good not pulled low on lapse");
	a_pg_wait_min: assert property (
		$fell(power_good_flag_oe_out) |-> ok_run >= QUAL_CYCLES)
		else $error("power good released before full delay");
	a_pg_wait_max: assert property (
		ok_run == QUAL_CYCLES + 4 |-> !power_good_flag_oe_out)
		else $error("power good held after delay expired");
	a_linear_on: assert property (
		$past(rst_n_in) |-> linear_drive_output_enable_out)
		else $error("linear output off after power-on");
	a_half_phase: assert property (
		$rose(gate_out[1].upper) && ph_cnt < PWM_PERIOD
		|-> ph_cnt == PWM_PERIOD / 2)
		else $error("second channel not at half period");
	c_pg_release: cover property ($fell(power_good_flag_oe_out));
	c_hiccup: cover property ($rose(gate_out[0].ss_discharge));
	c_latch: cover property ($fell(gate_out[0].oe));
endmodule
bind dbfs_top dbfs_sva #(
	.PWM_PERIOD(PWM_PERIOD),
	.MIN_ON(MIN_ON),
	.QUAL_CYCLES(QUAL_CYCLES)
) dbfs_sva_i (
	.sys_clk_in(sys_clk_in),
	.rst_n_in(rst_n_in),
	.ch_cmp_in(ch_cmp_in),
	.lin_above_75_in(lin_above_75_in),
	.gate_out(gate_out),
	.linear_drive_output_enable_out(linear_drive_output_enable_out),
	.power_good_flag_oe_out(power_good_flag_oe_out)
);

// *** verif/tb_dbfs_top.sv ***
// self-checking bench of the dual buck fault supervisor
`timescale 1ns/10ps
module tb_dbfs_top import dbfs_pkg::*;;
	localparam int PP = PWM_PERIOD_DEF;
	localparam int QC = 50;
	localparam logic [31:0] ONE = 32'h0000_0001;
	logic clk = 1'b0;
	logic rst_n, clk_en, lin_ok, pg, pg_oe, lin_en, pg_line, hready, hresp;
	logic [NCH-1:0] hold, low, high, uv, ov, oc;
	dbfs_cmp_t [NCH-1:0] cmp;
	dbfs_gate_t [NCH-1:0] gate;
	logic hsel, hwrite;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata;
	logic [6:0] mon;
	int err_count, check_count, n;
	always #2.5 clk = ~clk;
	// levels watched by the bounded waits
	assign mon = {hready, gate[1].softstart_done, gate[0].softstart_done,
		gate[0].oe, gate[1].ss_discharge, gate[0].ss_discharge, pg_oe};
	dbfs_top #(.QUAL_CYCLES(QC)) dbfs_top_i (.sys_clk_in(clk),
		.rst_n_in(rst_n), .clk_en_in(clk_en), .ch_cmp_in(cmp),
		.lin_above_75_in(lin_ok), .gate_out(gate),
		.linear_drive_output_enable_out(lin_en),
		.power_good_flag_out(pg), .power_good_flag_oe_out(pg_oe),
		.hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
		.hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
		.hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
		.hresp_out(hresp));
	dbfs_stage_model dbfs_stage_model_i (.sys_clk_in(clk), .rst_n_in(rst_n),
		.gate_in(gate), .hold_in(hold), .low_in(low), .high_in(high),
		.uv_in(uv), .ov_in(ov), .oc_in(oc), .pg_oe_in(pg_oe),
		.pg_data_in(pg), .cmp_out(cmp), .pg_line_out(pg_line));
	// verdict and end of run
	task automatic complete_run();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// compare seen against expected
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			err_count++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	// bounded wait for a watched level, sampled at rising edges
	task automatic wait_bit(input int b, input logic v, input int lim,
		output int k);
		k = 0;
		while (mon[b] !== v && k < lim) begin
			@(posedge clk);
			k++;
		end
		if (k >= lim) begin
			err_count++;
			$display("Error at %0t: wait %0d ran out", $time, b);
			complete_run();
		end
	endtask
	// one single AHB-Lite word transfer
	task automatic ahb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		int k;
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		hwrite <= wr;
		htrans <= 2'b10;
		@(posedge clk);
		wait_bit(6, 1'b1, 50, k);
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge clk);
		wait_bit(6, 1'b1, 50, k);
		rd = hrdata;
	endtask
	// read a register and compare
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		ahb(1'b0, a, WORD_ZERO, r);
		check(r, e);
		check(32'({pg, hresp}), WORD_ZERO);
	endtask
	function automatic logic [31:0] stat(input dbfs_ch_state_t s0,
		input dbfs_ch_state_t s1, input logic rel);
		return {22'h0, 1'b1, rel, 2'b00, s1, s0};
	endfunction
	// main sequence
	initial begin
		logic [31:0] r;
		rst_n <= 1'b0;
		clk_en <= 1'b1;
		lin_ok <= 1'b1;
		{hold, low, high, uv, ov, oc} <= '0;
		{hsel, hwrite, htrans, haddr, hwdata} <= '0;
		hsize <= 3'b010;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		wait_bit(0, 1'b0, 2000, n);
		check(32'(n >= 220 + QC), ONE);
		check(32'(pg_line), ONE);
		rd_chk(REG_STATUS, stat(CH_RUN, CH_RUN, 1'b1));
		for (int i = 0; i < 3; i++) begin
			low[0] <= (i == 0);
			high[1] <= (i == 1);
			lin_ok <= (i != 2);
			repeat (3) @(posedge clk);
			check(32'(pg_oe), ONE);
			{low, high, lin_ok} <= 5'b0_0001;
			wait_bit(0, 1'b0, 200, n);
			check(32'(n >= QC), ONE);
		end
		oc[0] <= 1'b1;
		wait_bit(1, 1'b1, 40 * PP, n);
		check(32'(n >= 31 * PP), ONE);
		wait_bit(1, 1'b0, 1000, n);
		wait_bit(1, 1'b1, 1000, n);
		check(32'(n < 31 * PP), ONE);
		check(32'(gate[1].softstart_done), ONE);
		oc[0] <= 1'b0;
		wait_bit(4, 1'b1, 2000, n);
		rd_chk(REG_STATUS, stat(CH_RUN, CH_RUN, 1'b0));
		uv[1] <= 1'b1;
		repeat (6 * PP) @(posedge clk);
		uv[1] <= 1'b0;
		repeat (PP) @(posedge clk);
		uv[1] <= 1'b1;
		wait_bit(2, 1'b1, 12 * PP, n);
		check(32'(n >= 7 * PP), ONE);
		uv[1] <= 1'b0;
		wait_bit(5, 1'b1, 2000, n);
		ov[0] <= 1'b1;
		wait_bit(3, 1'b0, 40 * PP, n);
		check(32'(n >= 31 * PP), ONE);
		rd_chk(REG_STATUS, stat(CH_LATCHED, CH_RUN, 1'b0));
		ov[0] <= 1'b0;
		uv[0] <= 1'b1;
		wait_bit(1, 1'b1, 12 * PP, n);
		check(32'(n >= 7 * PP), ONE);
		uv[0] <= 1'b0;
		hold[0] <= 1'b1;
		ahb(1'b1, REG_CTRL, 32'h0000_0002, r);
		repeat (4) @(posedge clk);
		rd_chk(REG_STATUS, stat(CH_OFF, CH_OFF, 1'b0));
		rd_chk(REG_CTRL, 32'h0000_0002);
		rd_chk(8'h10, WORD_ZERO);
		hold[0] <= 1'b0;
		ahb(1'b1, REG_CTRL, WORD_ZERO, r);
		wait_bit(0, 1'b0, 2000, n);
		rd_chk(REG_STATUS, stat(CH_RUN, CH_RUN, 1'b1));
		complete_run();
	end
endmodule
